// ==== common/nrps_pkg.sv ====
// Shared constants and types of the NAND read/program sequencer controller
package nrps_pkg;
	// Register offsets on APB
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR_A = 8'h04;
	localparam logic [7:0] REG_ADDR_B = 8'h08;
	localparam logic [7:0] REG_DATA   = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CTRL   = 8'h14;
	// Status and control field positions
	localparam int ST_BUSY = 0;
	localparam int ST_RDY  = 1;
	localparam int ST_ERR  = 2;
	localparam int ST_MULT = 3;
	localparam int ST_BYTE = 8;
	localparam int CTRL_WP = 0;
	localparam logic CTRL_WP_RST = 1'b0;
	// Address word layout: column [12:0], row [29:13]
	localparam int AW_ROW   = 13;
	localparam int AW_DIST  = 19;
	localparam int AW_PG_HI = 18;
	// Operations written to REG_CMD
	localparam logic [3:0] OP_READ  = 4'h0;
	localparam logic [3:0] OP_MREAD = 4'h1;
	localparam logic [3:0] OP_PSET  = 4'h2;
	localparam logic [3:0] OP_COL   = 4'h3;
	localparam logic [3:0] OP_PGO   = 4'h4;
	localparam logic [3:0] OP_MMID  = 4'h5;
	localparam logic [3:0] OP_S70   = 4'h6;
	localparam logic [3:0] OP_S71   = 4'h7;
	localparam logic [3:0] OP_ECC   = 4'h8;
	localparam logic [3:0] OP_RST   = 4'h9;
	localparam logic [3:0] OP_DWR   = 4'hA;
	localparam logic [3:0] OP_DRD   = 4'hB;
	// Command bytes on the flash port
	localparam logic [7:0] CMD_READ  = 8'h00;
	localparam logic [7:0] CMD_RGO   = 8'h30;
	localparam logic [7:0] CMD_MSEL  = 8'h60;
	localparam logic [7:0] CMD_PROG  = 8'h80;
	localparam logic [7:0] CMD_COL   = 8'h85;
	localparam logic [7:0] CMD_PGO   = 8'h10;
	localparam logic [7:0] CMD_PMID  = 8'h11;
	localparam logic [7:0] CMD_P2    = 8'h81;
	localparam logic [7:0] CMD_S70   = 8'h70;
	localparam logic [7:0] CMD_S71   = 8'h71;
	localparam logic [7:0] CMD_ECC   = 8'h7A;
	localparam logic [7:0] CMD_RST   = 8'hFF;
	// Step kinds of a sequence
	localparam logic [2:0] K_CMD = 3'h0;
	localparam logic [2:0] K_ADR = 3'h1;
	localparam logic [2:0] K_DAT = 3'h2;
	localparam logic [2:0] K_WT  = 3'h3;
	localparam logic [2:0] K_RD  = 3'h4;
	localparam logic [2:0] K_END = 3'h5;
	// Limits
	localparam logic [12:0] COL_LIMIT = 13'h1080;
	localparam logic [2:0]  MAX_PROGS = 3'h4;
	// Timing
	localparam int CLK_NS  = 25;
	localparam int TWB_NS  = 100;
	localparam int RD_NS   = 125;
	localparam int TWB_CYC = (TWB_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC  = (RD_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [8:0] {
		S_IDLE  = 9'b000000001,
		S_FETCH = 9'b000000010,
		S_WLOW  = 9'b000000100,
		S_WHIGH = 9'b000001000,
		S_BUSYW = 9'b000010000,
		S_RDYW  = 9'b000100000,
		S_RLOW  = 9'b001000000,
		S_RHIGH = 9'b010000000,
		S_SPARE = 9'b100000000
	} nrps_state_t;
endpackage

// ==== logic/nrps_ctrl.sv ====
// Host-side NAND read/program sequencer with APB register port
`timescale 1ns/1ps
// Function
// [RULE1] Page read: 00h, five addresses, 30h
// [RULE2] First read after power-up may skip 00h
// [RULE3] Multi read transfer starts at 30h, busy
// [RULE4] After ready, data streams from column
// [RULE5] ECC status only after single page read
// [RULE6] Even blocks district 0, odd district 1
// [RULE7] One block per district, same page bits
// [RULE8] District addresses in either order
// [RULE9] Write protect high during multi read
// [RULE10] Device corrects eight, detects nine errors
// [RULE11] Sector: 512 main plus 16 spare
// [RULE12] 70h returns read ECC outcome, kept
// [RULE13] Sector minimum unit, four programs per page
// [RULE14] Parity columns 4224-4351 inaccessible
// [RULE15] Main and spare in one program
// [RULE16] 10h starts automatic page programming
// [RULE17] 85h plus two addresses changes column
// [RULE18] Multi program: 80h,data,11h,81h,data,10h
// [RULE19] Between 11h and 81h only 70h/FFh
// [RULE20] 70h after multi program gives combined fail
// [RULE21] 71h byte gives per-district fail flags
// [RULE22] Command/address latched on rising write strobe
// [RULE23] Five address cycles, unused bits low
// [RULE24] Ready/busy low while operation runs
// [RULE25] Each falling read strobe gives next byte
module nrps_ctrl
	import nrps_pkg::*;
(
	input  logic        clk,          // 40 MHz clock
	input  logic        reset,        // Async reset, active high
	input  logic        psel,         // APB select
	input  logic        penable,      // APB enable
	input  logic        pwrite,       // APB direction
	input  logic [7:0]  paddr,        // APB byte address
	input  logic [31:0] pwdata,       // APB write data
	output logic [31:0] prdata,       // APB read data
	output logic        pready,       // APB ready
	output logic        pslverr,      // APB error
	output logic        cmd_latch,    // Command latch enable
	output logic        addr_latch,   // Address latch enable
	output logic        chip_en_n,    // Chip enable, low active
	output logic        write_strobe_n, // Write strobe, low active
	output logic        read_strobe_n,  // Read strobe, low active
	output logic        wprot_n,      // Write protect, low protects
	input  logic        ready_busy_n, // Open-drain ready/busy level
	input  logic [7:0]  io_i,         // Shared port, input level
	output logic [7:0]  io_o,         // Shared port, drive value
	output logic [7:0]  io_oe         // Shared port, drive enable
);
	nrps_state_t state_q, state_d;
	logic [3:0]  idx_q, idx_d, op_q, op_d, cnt_q, cnt_d;
	logic        first_q, first_d, multi_q, multi_d, err_q, err_d, dpend_q, dpend_d;
	logic [2:0]  pcnt_q, pcnt_d;
	logic [16:0] prow_q, prow_d;
	logic [29:0] adr_a_q, adr_a_d, adr_b_q, adr_b_d;
	logic [7:0]  wdat_q, wdat_d, stat_q, stat_d, rbyte_q, rbyte_d, io_o_q, io_o_d;
	logic        wp_q, wp_d, pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic        cle_q, cle_d, ale_q, ale_d, ce_n_q, ce_n_d, we_n_q, we_n_d;
	logic        re_n_q, re_n_d, oe_q, oe_d, wpo_q, wpo_d;
	logic [8:0]  sync_q;
	logic        rb_s, start, legal, setup, acc;
	logic [3:0]  start_op;
	logic [10:0] step;

	nrps_pin_sync #(.W(9), .RST_VAL(9'h100)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({ready_busy_n, io_i}),
		.q     (sync_q)
	);
	assign rb_s = sync_q[8];

	function automatic logic [7:0] adr_byte(input logic [29:0] w, input logic [3:0] n);
		case (n)
			4'h0: adr_byte = w[7:0];
			4'h1: adr_byte = {3'h0, w[12:8]};
			4'h2: adr_byte = w[20:13];
			4'h3: adr_byte = w[28:21];
			default: adr_byte = {7'h00, w[29]}; // RULE23
		endcase
	endfunction

	// Step table: {kind, byte} for step i of an operation
	function automatic logic [10:0] seq_step(input logic [3:0] op, input logic [3:0] i,
		input logic [29:0] a, input logic [29:0] b, input logic [7:0] wd);
		seq_step = {K_END, 8'h00};
		case (op)
			OP_READ: begin // RULE1
				if (i == 4'h0) seq_step = {K_CMD, CMD_READ};
				else if (i <= 4'h5) seq_step = {K_ADR, adr_byte(a, i - 4'h1)};
				else if (i == 4'h6) seq_step = {K_CMD, CMD_RGO};
				else if (i == 4'h7) seq_step = {K_WT, 8'h00}; // RULE4
			end
			OP_MREAD: begin // RULE3
				if (i == 4'h0 || i == 4'h6) seq_step = {K_CMD, CMD_MSEL};
				else if (i <= 4'h5) seq_step = {K_ADR, adr_byte(a, i - 4'h1)};
				else if (i <= 4'hB) seq_step = {K_ADR, adr_byte(b, i - 4'h7)};
				else if (i == 4'hC) seq_step = {K_CMD, CMD_RGO};
				else if (i == 4'hD) seq_step = {K_WT, 8'h00};
			end
			OP_PSET: begin
				if (i == 4'h0) seq_step = {K_CMD, CMD_PROG};
				else if (i <= 4'h5) seq_step = {K_ADR, adr_byte(a, i - 4'h1)};
			end
			OP_COL: begin // RULE17 RULE15
				if (i == 4'h0) seq_step = {K_CMD, CMD_COL};
				else if (i <= 4'h2) seq_step = {K_ADR, adr_byte(a, i - 4'h1)};
			end
			OP_PGO: begin // RULE16
				if (i == 4'h0) seq_step = {K_CMD, CMD_PGO};
				else if (i == 4'h1) seq_step = {K_WT, 8'h00};
			end
			OP_MMID: begin // RULE18 RULE19
				if (i == 4'h0) seq_step = {K_CMD, CMD_PMID};
				else if (i == 4'h1) seq_step = {K_WT, 8'h00};
				else if (i == 4'h2) seq_step = {K_CMD, CMD_P2};
				else if (i <= 4'h7) seq_step = {K_ADR, adr_byte(b, i - 4'h3)};
			end
			OP_S70, OP_S71, OP_ECC: begin // RULE12 RULE20 RULE21
				if (i == 4'h0) seq_step = {K_CMD, (op == OP_S70) ? CMD_S70 :
					(op == OP_S71) ? CMD_S71 : CMD_ECC};
				else if (i == 4'h1) seq_step = {K_RD, 8'h00};
			end
			OP_RST: begin
				if (i == 4'h0) seq_step = {K_CMD, CMD_RST};
				else if (i == 4'h1) seq_step = {K_WT, 8'h00};
			end
			OP_DWR: if (i == 4'h0) seq_step = {K_DAT, wd};
			OP_DRD: if (i == 4'h0) seq_step = {K_RD, 8'h00};
			default: seq_step = {K_END, 8'h00};
		endcase
	endfunction

	assign step = seq_step(op_q, idx_q, adr_a_q, adr_b_q, wdat_q);

	////////////////////////////////////////////////////////////////////////////
	// Flash port sequencer
	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		op_d    = op_q;
		cnt_d   = cnt_q;
		first_d = first_q;
		multi_d = multi_q;
		stat_d  = stat_q;
		rbyte_d = rbyte_q;
		io_o_d  = io_o_q;
		cle_d   = cle_q;
		ale_d   = ale_q;
		we_n_d  = we_n_q;
		re_n_d  = re_n_q;
		oe_d    = oe_q;
		case (state_q)
			S_IDLE: if (start) begin
				op_d    = start_op;
				// Power-up leaves 00h latched, so the first read skips it
				idx_d   = (start_op == OP_READ && first_q) ? 4'h1 : 4'h0; // RULE2
				state_d = S_FETCH;
			end
			S_FETCH: begin
				cle_d = 1'b0;
				ale_d = 1'b0;
				oe_d  = 1'b0;
				case (step[10:8])
					K_CMD, K_ADR, K_DAT: begin
						cle_d   = (step[10:8] == K_CMD);
						ale_d   = (step[10:8] == K_ADR);
						io_o_d  = step[7:0];
						oe_d    = 1'b1;
						state_d = S_WLOW;
					end
					K_WT: begin
						cnt_d   = 4'(TWB_CYC);
						state_d = S_BUSYW;
					end
					K_RD: begin
						re_n_d  = 1'b0; // RULE25
						cnt_d   = 4'(RD_CYC);
						state_d = S_RLOW;
					end
					default: begin
						if (op_q == OP_READ || op_q == OP_MREAD || op_q == OP_PSET ||
							op_q == OP_RST) begin
							first_d = 1'b0;
							multi_d = (op_q == OP_MREAD);
						end
						state_d = S_IDLE;
					end
				endcase
			end
			S_WLOW: begin
				we_n_d  = 1'b0;
				state_d = S_WHIGH;
			end
			S_WHIGH: begin
				we_n_d  = 1'b1; // RULE22
				idx_d   = idx_q + 4'h1;
				state_d = S_FETCH;
			end
			// Busy may show late, so wait the least delay unless low is seen first
			S_BUSYW: begin
				if (!rb_s || cnt_q == 4'h0) state_d = S_RDYW;
				else cnt_d = cnt_q - 4'h1;
			end
			S_RDYW: if (rb_s) begin // RULE24
				idx_d   = idx_q + 4'h1;
				state_d = S_FETCH;
			end
			S_RLOW: begin
				if (cnt_q == 4'h0) begin
					if (op_q == OP_DRD) rbyte_d = sync_q[7:0];
					else stat_d = sync_q[7:0];
					re_n_d  = 1'b1;
					state_d = S_RHIGH;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			S_RHIGH: begin
				idx_d   = idx_q + 4'h1;
				state_d = S_FETCH;
			end
			default: state_d = S_IDLE;
		endcase
		ce_n_d = (state_d == S_IDLE);
		wpo_d  = wp_q | (state_d != S_IDLE && op_d == OP_MREAD); // RULE9
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= S_IDLE;
			idx_q   <= 4'h0;
			op_q    <= OP_READ;
			cnt_q   <= 4'h0;
			first_q <= 1'b1;
			multi_q <= 1'b0;
			stat_q  <= 8'h00;
			rbyte_q <= 8'h00;
			io_o_q  <= 8'h00;
			cle_q   <= 1'b0;
			ale_q   <= 1'b0;
			we_n_q  <= 1'b1;
			re_n_q  <= 1'b1;
			oe_q    <= 1'b0;
			ce_n_q  <= 1'b1;
			wpo_q   <= CTRL_WP_RST;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			op_q    <= op_d;
			cnt_q   <= cnt_d;
			first_q <= first_d;
			multi_q <= multi_d;
			stat_q  <= stat_d;
			rbyte_q <= rbyte_d;
			io_o_q  <= io_o_d;
			cle_q   <= cle_d;
			ale_q   <= ale_d;
			we_n_q  <= we_n_d;
			re_n_q  <= re_n_d;
			oe_q    <= oe_d;
			ce_n_q  <= ce_n_d;
			wpo_q   <= wpo_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB registers
	assign setup = psel && !penable;
	assign acc   = psel && penable;
	// District is the block number's lowest bit; order of A and B is free
	assign legal = (pwdata[3:0] <= OP_RST) &&
		!((pwdata[3:0] == OP_MREAD || pwdata[3:0] == OP_MMID) &&
		  (adr_a_q[AW_DIST] == adr_b_q[AW_DIST] ||
		   adr_a_q[AW_PG_HI:AW_ROW] != adr_b_q[AW_PG_HI:AW_ROW])) && // RULE6 RULE7 RULE8
		!((pwdata[3:0] == OP_READ || pwdata[3:0] == OP_MREAD || pwdata[3:0] == OP_PSET ||
		   pwdata[3:0] == OP_COL) && adr_a_q[12:0] >= COL_LIMIT) && // RULE14 RULE11
		!(pwdata[3:0] == OP_ECC && multi_q) && // RULE5
		!(pwdata[3:0] == OP_PGO && pcnt_q == MAX_PROGS); // RULE13

	always_comb begin
		start     = 1'b0;
		start_op  = pwdata[3:0];
		err_d     = err_q;
		pcnt_d    = pcnt_q;
		prow_d    = prow_q;
		adr_a_d   = adr_a_q;
		adr_b_d   = adr_b_q;
		wdat_d    = wdat_q;
		wp_d      = wp_q;
		dpend_d   = dpend_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		if (setup && paddr != REG_DATA) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			case (paddr)
				REG_CMD:    prdata_d[3:0] = op_q;
				REG_ADDR_A: prdata_d[29:0] = adr_a_q;
				REG_ADDR_B: prdata_d[29:0] = adr_b_q;
				REG_CTRL:   prdata_d[CTRL_WP] = wp_q;
				REG_STATUS: begin
					prdata_d[ST_BUSY] = (state_q != S_IDLE);
					prdata_d[ST_RDY]  = rb_s;
					prdata_d[ST_ERR]  = err_q;
					prdata_d[ST_MULT] = multi_q;
					prdata_d[ST_BYTE +: 8] = stat_q;
				end
				default: pslverr_d = 1'b1;
			endcase
			if (pwrite) begin
				case (paddr)
					REG_ADDR_A: adr_a_d = pwdata[29:0];
					REG_ADDR_B: adr_b_d = pwdata[29:0];
					REG_CTRL:   wp_d = pwdata[CTRL_WP];
					REG_STATUS: if (pwdata[ST_ERR]) err_d = 1'b0;
					REG_CMD: begin
						if (state_q == S_IDLE && legal) begin
							start = 1'b1;
							if (start_op == OP_PSET && adr_a_q[29:AW_ROW] != prow_q) begin
								prow_d = adr_a_q[29:AW_ROW];
								pcnt_d = 3'h0;
							end
							if (start_op == OP_PGO) pcnt_d = pcnt_q + 3'h1; // RULE13
						end else begin
							err_d = 1'b1; // Refused start; the flag clears only on a separate REG_STATUS write
						end
					end
					default: ;
				endcase
			end
		end else if (acc && paddr == REG_DATA && !pready_q) begin
			// The bus waits for the byte cycle; no separate buffer is kept
			if (!dpend_q && state_q == S_IDLE) begin
				start    = 1'b1;
				start_op = pwrite ? OP_DWR : OP_DRD;
				wdat_d   = pwdata[7:0];
				dpend_d  = 1'b1;
			end else if (dpend_q && state_q == S_IDLE) begin
				pready_d = 1'b1;
				prdata_d = {24'h00_0000, rbyte_q};
				dpend_d  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err_q     <= 1'b0;
			pcnt_q    <= 3'h0;
			prow_q    <= 17'h0_0000;
			adr_a_q   <= 30'h0000_0000;
			adr_b_q   <= 30'h0000_0000;
			wdat_q    <= 8'h00;
			wp_q      <= CTRL_WP_RST;
			dpend_q   <= 1'b0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			err_q     <= err_d;
			pcnt_q    <= pcnt_d;
			prow_q    <= prow_d;
			adr_a_q   <= adr_a_d;
			adr_b_q   <= adr_b_d;
			wdat_q    <= wdat_d;
			wp_q      <= wp_d;
			dpend_q   <= dpend_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cmd_latch = cle_q;
	assign addr_latch = ale_q;
	assign chip_en_n = ce_n_q;
	assign write_strobe_n = we_n_q;
	assign read_strobe_n = re_n_q;
	assign wprot_n = wpo_q;
	assign io_o = io_o_q;
	assign io_oe = {8{oe_q}};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	wp_multi_a: assert property (state_q != S_IDLE && op_q == OP_MREAD |-> wprot_n) // RULE9
		else $error("write protect low during multi read");
	latch_excl_a: assert property (!(cmd_latch && addr_latch)) // RULE22
		else $error("both latch enables high");
	strobe_drv_a: assert property ($rose(write_strobe_n) |-> io_oe[0] && $past(io_oe[0])) // RULE22
		else $error("port not driven across write strobe");
	ecc_multi_a: assert property (cmd_latch && io_o == CMD_ECC |-> !multi_q) // RULE5
		else $error("ECC status after multi read");
	dist_bad_a: assert property (setup && pwrite && paddr == REG_CMD &&
		pwdata[3:0] == OP_MREAD && adr_a_q[AW_DIST] == adr_b_q[AW_DIST] |=> err_q) // RULE7
		else $error("same-district multi request not refused");
	prog_cnt_a: assert property (pcnt_q <= MAX_PROGS) // RULE13
		else $error("page programmed too often");
	addr_top_a: assert property (op_q == OP_READ && idx_q == 4'h5 && state_q == S_WHIGH
		|-> io_o[7:1] == 7'h00) // RULE23
		else $error("fifth address cycle upper bits set");
	mmid_seq_a: assert property (op_q == OP_MMID && idx_q == 4'h2 && state_q == S_WHIGH
		|-> cmd_latch && io_o == CMD_P2) // RULE19
		else $error("wrong command after 11h");
	ready_acc_a: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");

	read_cov_c: cover property (state_q == S_FETCH && op_q == OP_READ && step[10:8] == K_END);
	mread_cov_c: cover property (state_q == S_FETCH && op_q == OP_MREAD && step[10:8] == K_END);
	mmid_cov_c: cover property (state_q == S_FETCH && op_q == OP_MMID && step[10:8] == K_END);
	drd_cov_c: cover property (pready && paddr == REG_DATA && !pwrite);
endmodule

// ==== logic/nrps_pin_sync.sv ====
// Three-stage synchroniser for flash pin inputs
`timescale 1ns/1ps
module nrps_pin_sync #(
	parameter int W = 9,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  logic         clk,   // System clock
	input  logic         reset, // Async reset, active high
	input  logic [W-1:0] d,     // Pin levels
	output logic [W-1:0] q      // Filtered levels
);
	logic [W-1:0] s1_q, s2_q, s3_q, q_q;
	logic [W-1:0] q_d;

	// Per bit: a change counts once the second and third stages agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q_q  <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q  <= q_d;
		end
	end

	assign q = q_q;
endmodule

// ==== sim/nrps_flash_model.sv ====
// Behavioural model of the flash device seen by the sequencer
`timescale 1ns/1ps
module nrps_flash_model
	import nrps_pkg::*;
#(
	parameter int BUSY_NS = 500 // Array busy time, shortened
) (
	input  wire logic       chip_en_n,      // Chip enable, low active
	input  wire logic       cmd_latch,      // Command latch enable
	input  wire logic       addr_latch,     // Address latch enable
	input  wire logic       write_strobe_n, // Write strobe, low active
	input  wire logic       read_strobe_n,  // Read strobe, low active
	input  wire logic       wprot_n,        // Write protect level
	input  wire logic       fail_d1,        // Bench order: district 1 fails
	input  wire logic [7:0] bus_level,      // Resolved port level
	output logic      [7:0] dev_io,         // Value the device shows
	output logic            rb_low          // Pulls ready/busy low
);
	logic [8:0]  log_q [$];
	logic [7:0]  mem [0:63];
	logic [7:0]  cmd_q;
	logic [2:0]  acnt_q;
	logic [12:0] col_q;
	logic [16:0] row_q;
	logic        d1_q;
	logic [1:0]  fail_q;
	////////////////////////////////////////
	// One page only: enough to see data order, not a full array
	initial begin
		cmd_q = CMD_READ;
		acnt_q = '0;
		col_q = '0;
		row_q = '0;
		d1_q = 1'b0;
		fail_q = '0;
		rb_low = 1'b0;
		dev_io = 8'h00;
		for (int i = 0; i < 64; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	task automatic go_busy();
		rb_low = 1'b1;
		#(BUSY_NS);
		rb_low = 1'b0;
	endtask
	always @(posedge write_strobe_n) begin
		if (!chip_en_n && cmd_latch) begin
			log_q.push_back({1'b1, bus_level});
			cmd_q = bus_level;
			acnt_q = '0;
			if (bus_level == CMD_PROG)
				d1_q = 1'b0;
			if (bus_level == CMD_PGO)
				fail_q = {fail_d1 & d1_q, 1'b0};
			if (bus_level inside {CMD_RGO, CMD_PGO, CMD_PMID, CMD_RST})
				fork
					go_busy();
				join_none
		end else if (!chip_en_n && addr_latch) begin
			log_q.push_back({1'b0, bus_level});
			case (acnt_q)
				3'h0: col_q[7:0] = bus_level;
				3'h1: col_q[12:8] = bus_level[4:0];
				3'h2: row_q[7:0] = bus_level;
				3'h3: row_q[15:8] = bus_level;
				default: row_q[16] = bus_level[0];
			endcase
			if (acnt_q == 3'h2 && bus_level[6])
				d1_q = 1'b1;
			acnt_q = acnt_q + 3'h1;
		end else if (!chip_en_n) begin
			mem[col_q[5:0]] = bus_level;
			col_q = col_q + 13'h1;
		end
	end
	always @(negedge read_strobe_n) begin
		if (!chip_en_n) begin
			case (cmd_q)
				CMD_S70: dev_io = {wprot_n, 2'b11, 4'h0, |fail_q};
				CMD_S71: dev_io = {wprot_n, 2'b11, 2'b00, fail_q, |fail_q};
				CMD_ECC: dev_io = 8'h01;
				default: begin
					dev_io = mem[col_q[5:0]];
					col_q = col_q + 13'h1;
				end
			endcase
		end
	end
	// Port is not pulled: show a changed value once released
	always @(posedge read_strobe_n)
		dev_io = ~dev_io;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench of the sequencer against the device model
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
	end \
end
module tb_top
	import nrps_pkg::*;
;
	localparam logic [29:0] A1 = 30'h0008_2005;
	localparam logic [29:0] B0 = 30'h0000_2002;
	localparam logic [29:0] P3 = 30'h0010_0003;
	localparam logic [29:0] P9 = 30'h0010_0009;
	localparam logic [29:0] PX = 30'h0010_1080;
	int          mismatches;
	int          check_count;
	logic        clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cmd_latch;
	logic        addr_latch;
	logic        chip_en_n;
	logic        write_strobe_n;
	logic        read_strobe_n;
	logic        wprot_n;
	logic        ready_busy_n;
	logic [7:0]  io_i;
	logic [7:0]  io_o;
	logic [7:0]  io_oe;
	logic [7:0]  dev_io;
	logic        rb_low;
	logic        fail_d1;
	logic [8:0]  exp_q [$];
	assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
	assign io_i = io_oe[0] ? io_o : dev_io;
	nrps_ctrl u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .chip_en_n(chip_en_n), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .wprot_n(wprot_n), .ready_busy_n(ready_busy_n),
		.io_i(io_i), .io_o(io_o), .io_oe(io_oe));
	nrps_flash_model #(.BUSY_NS(500)) u_flash (.chip_en_n(chip_en_n),
		.cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .wprot_n(wprot_n), .fail_d1(fail_d1),
		.bus_level(io_i), .dev_io(dev_io), .rb_low(rb_low));
	always #12.5 clk = ~clk;
	////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic op(input logic [3:0] o);
		logic [31:0] s;
		wr(REG_CMD, {28'h0, o});
		s = 32'h1;
		while (s[ST_BUSY] !== 1'b0)
			rd(REG_STATUS, s);
	endtask
	task automatic ec(input logic [7:0] b);
		exp_q.push_back({1'b1, b});
	endtask
	// Expected address bytes: column low, column high, three row bytes
	task automatic ea(input logic [29:0] w, input int n);
		logic [7:0] b [5];
		b = '{w[7:0], {3'h0, w[12:8]}, w[20:13], w[28:21], {7'h0, w[29]}};
		for (int i = 0; i < n; i++)
			exp_q.push_back({1'b0, b[i]});
	endtask
	task automatic chk_log();
		`CHK(u_flash.log_q.size(), exp_q.size())
		for (int i = 0; i < exp_q.size() && i < u_flash.log_q.size(); i++)
			`CHK(u_flash.log_q[i], exp_q[i])
		u_flash.log_q.delete();
		exp_q.delete();
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_CTRL, r);
		`CHK(r, 32'h0000_0001)
		`CHK(wprot_n, 1'b1)
		apb(1'b0, 8'h40, 32'h0, r, e);
		`CHK({e, r}, 33'h1_0000_0000)
	endtask
	task automatic t_reads();
		logic [31:0] r;
		wr(REG_ADDR_A, {2'b00, A1});
		op(OP_READ);
		ea(A1, 5);
		ec(CMD_RGO);
		chk_log();
		rd(REG_DATA, r);
		`CHK(r, {24'h0, 8'h05 ^ 8'h5A})
		rd(REG_DATA, r);
		`CHK(r, {24'h0, 8'h06 ^ 8'h5A})
		op(OP_READ);
		op(OP_ECC);
		ec(CMD_READ);
		ea(A1, 5);
		ec(CMD_RGO);
		ec(CMD_ECC);
		chk_log();
		rd(REG_STATUS, r);
		`CHK({r[15:8], r[ST_ERR]}, 9'h002)
	endtask
	task automatic t_mread();
		logic [31:0] r;
		wr(REG_CTRL, 32'h0);
		wr(REG_ADDR_B, {2'b00, B0});
		wr(REG_CMD, {28'h0, OP_MREAD});
		while (rb_low !== 1'b1)
			@(posedge clk);
		`CHK(wprot_n, 1'b1)
		`CHK(u_flash.log_q[$], {1'b1, CMD_RGO})
		// Let the multi read finish so the refusal below comes from the multi flag
		r = 32'h1;
		while (r[ST_BUSY] !== 1'b0)
			rd(REG_STATUS, r);
		`CHK(r[ST_MULT], 1'b1)
		op(OP_ECC);
		ec(CMD_MSEL);
		ea(A1, 5);
		ec(CMD_MSEL);
		ea(B0, 5);
		ec(CMD_RGO);
		chk_log();
		rd(REG_STATUS, r);
		`CHK(r[ST_ERR], 1'b1)
		wr(REG_STATUS, 32'h0000_0004);
		wr(REG_ADDR_B, {2'b00, A1});
		op(OP_MREAD);
		rd(REG_STATUS, r);
		`CHK(r[ST_ERR], 1'b1)
		chk_log();
		wr(REG_STATUS, 32'h0000_0004);
		wr(REG_CTRL, 32'h0000_0001);
	endtask
	task automatic t_prog();
		logic [31:0] r;
		wr(REG_ADDR_A, {2'b00, P3});
		op(OP_PSET);
		wr(REG_DATA, 32'h0000_0011);
		wr(REG_ADDR_A, {2'b00, PX});
		op(OP_COL);
		rd(REG_STATUS, r);
		`CHK(r[ST_ERR], 1'b1)
		wr(REG_STATUS, 32'h0000_0004);
		wr(REG_ADDR_A, {2'b00, P9});
		op(OP_COL);
		wr(REG_DATA, 32'h0000_0022);
		op(OP_PGO);
		ec(CMD_PROG);
		ea(P3, 5);
		ec(CMD_COL);
		ea(P9, 2);
		ec(CMD_PGO);
		chk_log();
		`CHK({u_flash.mem[3], u_flash.mem[9]}, 16'h1122)
	endtask
	task automatic t_mprog();
		logic [31:0] r;
		fail_d1 <= 1'b1;
		wr(REG_ADDR_A, {2'b00, B0});
		op(OP_PSET);
		wr(REG_DATA, 32'h0000_0033);
		op(OP_MMID);
		wr(REG_DATA, 32'h0000_0044);
		op(OP_PGO);
		ec(CMD_PROG);
		ea(B0, 5);
		ec(CMD_PMID);
		ec(CMD_P2);
		ea(A1, 5);
		ec(CMD_PGO);
		chk_log();
		op(OP_S71);
		rd(REG_STATUS, r);
		`CHK(r[15:8], 8'hE5)
		op(OP_S70);
		rd(REG_STATUS, r);
		`CHK(r[15:8], 8'hE1)
		// Three more starts reach the limit; the fourth must be refused
		repeat (4) op(OP_PGO);
		rd(REG_STATUS, r);
		`CHK(r[ST_ERR], 1'b1)
	endtask
	task automatic tally_and_finish();
		$display("Counts: checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#(25 * 40000);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, fail_d1} = '0;
		mismatches = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		`CHK({chip_en_n, write_strobe_n, read_strobe_n, cmd_latch, addr_latch}, 5'h1C)
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		// Ready/busy synchroniser needs a few cycles after reset
		repeat (5) @(posedge clk);
		t_regs();
		t_reads();
		t_mread();
		t_prog();
		t_mprog();
		tally_and_finish();
	end
endmodule
